/* File: rtl/asrp_port.sv */
// serial result port with apb registers, interrupt and shared pins
//
// Contract
// - non-serial modes drive pins as parallel bits
// - external clock serial makes pin9 chain input
// - chain input reappears after 18 bit clocks
// - read-timing high shifts during conversion
// - read-timing low shifts after conversion done
// - result leaves msb first
// - coding select picks result number format
// - internal clock bits valid both edges
// - invert low: change rising, host samples falling
// - invert high: change falling, host samples rising
// - clock pin direction by source select
// - frame marker only with internal clock
// - marker polarity low: marker high while valid
// - marker polarity high: marker low while valid
// - internal clock driven out, else follow external
// - unfinished slave read at done: drop, pulse flag
// - busy from conversion start until result latched
// - outputs enabled only while chip select, read low, except pin13 flag, enabled whenever external clock serial
//
// Register access over APB and the register offsets were chosen for this implementation.
module asrp_port
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [7:0]                 paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic                       conv_start,
  input  wire logic                       conv_done,
  input  wire logic [asrp_pkg::RES_W-1:0] conv_result,
  output logic                            busy,
  input  wire logic                       cs_n,
  input  wire logic                       rd_n,
  input  wire logic                       parallel_bit_9_i,
  output logic                            parallel_bit_9_o,
  output logic                            parallel_bit_9_oe,
  output logic                            parallel_bit_10_o,
  output logic                            parallel_bit_10_oe,
  input  wire logic                       parallel_bit_11_i,
  output logic                            parallel_bit_11_o,
  output logic                            parallel_bit_11_oe,
  output logic                            parallel_bit_12_o,
  output logic                            parallel_bit_12_oe,
  output logic                            parallel_bit_13_o,
  output logic                            parallel_bit_13_oe
);
  import asrp_pkg::*;

  typedef struct packed {
    asrp_state_t      state;
    logic [5:0]       ctrl;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] shreg;
    logic [4:0]       bitcnt;
    logic [2:0]       tcnt;
    logic             rderr;
    logic [3:0]       rderr_cnt;
    logic             busy;
    logic             fresh;
    logic [2:0]       istat;
    logic [2:0]       imask;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             sclk_prev;
    logic [4:0]       pin_out;
    logic [4:0]       pin_oe;
  } asrp_regs_t;

  asrp_regs_t q;
  asrp_regs_t d;

  logic [3:0]       sync_out;
  logic             chain_in;
  logic             sclk_s;
  logic             csn_s;
  logic             rdn_s;
  logic             en;
  logic             serial;
  logic             ext;
  logic             act_edge;
  logic             sclk_int;
  logic             marker_act;
  logic [2:0]       ev;
  logic [2:0]       w1c;
  logic [RES_W-1:0] coded;
  logic             hit;
  logic [31:0]      rdata;

  // ==================================================================
  // pin inputs through two flip-flops
  asrp_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({parallel_bit_9_i, parallel_bit_11_i, cs_n, rd_n}),
    .dout    (sync_out)
  );

  assign chain_in = sync_out[3];
  assign sclk_s   = sync_out[2];
  assign csn_s    = sync_out[1];
  assign rdn_s    = sync_out[0];

  // ==================================================================
  // decode of mode, clocking and enable
  assign en     = !csn_s && !rdn_s;
  assign serial = q.ctrl[CTRL_MODE +: 2] == MODE_SERIAL;
  assign ext    = q.ctrl[CTRL_CLKSRC];

  // chip select gates the external clock; the edge chosen by invert moves data
  assign act_edge = en && (q.ctrl[CTRL_EDGEINV] ? (!sclk_s && q.sclk_prev)
                                                : (sclk_s && !q.sclk_prev));

  // data changes at tick 0, the clock rises a quarter later and falls at three
  // quarters, so each bit is settled around both internal edges
  assign sclk_int = (q.state == ST_SHIFT) && !ext &&
                    (q.tcnt >= 3'(INT_QTR_CYC)) && (q.tcnt < 3'(3 * INT_QTR_CYC));

  assign marker_act = (q.state != ST_IDLE) && !ext;

  assign coded = q.ctrl[CTRL_CODING] ? conv_result
                                     : {~conv_result[RES_W-1], conv_result[RES_W-2:0]};

  // ==================================================================
  // register read decode
  always_comb
  begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      OFF_CTRL:   rdata[CTRL_W-1:0] = q.ctrl;
      OFF_STAT:
      begin
        rdata[STAT_BUSY]  = q.busy;
        rdata[STAT_FRESH] = q.fresh;
        rdata[STAT_READ]  = q.state != ST_IDLE;
        rdata[STAT_CHAIN] = q.state == ST_CHAIN;
      end
      OFF_ISTAT:  rdata[IRQ_W-1:0] = q.istat;
      OFF_IMASK:  rdata[IRQ_W-1:0] = q.imask;
      OFF_RESULT: rdata[RES_W-1:0] = q.result;
      default:    hit = 1'b0;
    endcase
  end

  // ==================================================================
  // next state
  always_comb
  begin
    d           = q;
    ev          = 3'h0;
    w1c         = 3'h0;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    d.sclk_prev = sclk_s;

    // apb: one wait cycle, then pready; a write lands at the pready edge
    if (psel && penable && !q.pready)
    begin
      d.pready  = 1'b1;
      d.pslverr = !hit;
      d.prdata  = rdata;
    end
    if (psel && penable && q.pready && pwrite)
    begin
      if (paddr == OFF_CTRL)
      begin
        d.ctrl = pwdata[CTRL_W-1:0];
      end
      if (paddr == OFF_ISTAT)
      begin
        w1c = pwdata[IRQ_W-1:0];
      end
      if (paddr == OFF_IMASK)
      begin
        d.imask = pwdata[IRQ_W-1:0];
      end
    end

    // read sequence
    case (q.state)
      ST_IDLE:
      begin
        if (serial && en && q.fresh &&
            (ext || (chain_in ? q.busy : !q.busy)))
        begin
          d.state  = ST_SHIFT;
          d.shreg  = q.result;
          d.bitcnt = 5'h00;
          d.tcnt   = 3'h0;
          d.fresh  = 1'b0;
        end
      end
      ST_SHIFT:
      begin
        if (!serial)
        begin
          d.state = ST_IDLE;
        end
        else if (ext)
        begin
          if (conv_done)
          begin
            d.state = ST_IDLE;
            ev[IRQ_RD_ERR] = 1'b1;
          end
          else if (act_edge)
          begin
            d.shreg  = {q.shreg[RES_W-2:0], chain_in};
            d.bitcnt = q.bitcnt + 5'h01;
            if (q.bitcnt == 5'(RES_W - 1))
            begin
              d.state = ST_CHAIN;
              ev[IRQ_READ_DONE] = 1'b1;
            end
          end
        end
        else if (!en)
        begin
          d.state = ST_IDLE;
        end
        else if (q.tcnt == 3'(INT_BIT_CYC - 1))
        begin
          d.tcnt   = 3'h0;
          d.shreg  = {q.shreg[RES_W-2:0], 1'b0};
          d.bitcnt = q.bitcnt + 5'h01;
          if (q.bitcnt == 5'(RES_W - 1))
          begin
            d.state = ST_IDLE;
            ev[IRQ_READ_DONE] = 1'b1;
          end
        end
        else
        begin
          d.tcnt = q.tcnt + 3'h1;
        end
      end
      ST_CHAIN:
      begin
        if (!serial || !ext || !en)
        begin
          d.state = ST_IDLE;
        end
        else if (act_edge)
        begin
          d.shreg = {q.shreg[RES_W-2:0], chain_in};
        end
      end
      default:
      begin
        d.state = ST_IDLE;
      end
    endcase

    // conversion bookkeeping after the fsm so a new result keeps fresh set
    if (conv_done)
    begin
      d.busy   = 1'b0;
      d.result = coded;
      d.fresh  = 1'b1;
      ev[IRQ_CONV_DONE] = 1'b1;
    end
    else if (conv_start)
    begin
      d.busy = 1'b1;
    end

    // incomplete-read pulse, retriggered by a new error
    if (ev[IRQ_RD_ERR])
    begin
      d.rderr     = 1'b1;
      d.rderr_cnt = 4'(RDERR_CYC - 1);
    end
    else if (q.rderr)
    begin
      if (q.rderr_cnt == 4'h0)
      begin
        d.rderr = 1'b0;
      end
      else
      begin
        d.rderr_cnt = q.rderr_cnt - 4'h1;
      end
    end

    // a new event beats a clear in the same cycle
    d.istat = (q.istat & ~w1c) | ev;
    d.irq   = |(d.istat & d.imask);

    // shared pins
    if (!serial)
    begin
      d.pin_out = q.result[13:9];
      d.pin_oe  = {5{en}};
    end
    else
    begin
      d.pin_out[PIN_9]  = 1'b0;
      d.pin_oe[PIN_9]   = 1'b0;
      d.pin_out[PIN_10] = (q.state != ST_IDLE) && q.shreg[RES_W-1];
      d.pin_oe[PIN_10]  = en;
      d.pin_out[PIN_11] = sclk_int ^ q.ctrl[CTRL_EDGEINV];
      d.pin_oe[PIN_11]  = en && !ext;
      d.pin_out[PIN_12] = marker_act ^ q.ctrl[CTRL_MKPOL];
      d.pin_oe[PIN_12]  = en && !ext;
      d.pin_out[PIN_13] = q.rderr;
      d.pin_oe[PIN_13]  = ext;
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q       <= '0;
      q.state <= ST_IDLE;
      q.ctrl  <= CTRL_RST;
      q.istat <= ISTAT_RST;
      q.imask <= IMASK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign irq                = q.irq;
  assign busy               = q.busy;
  assign parallel_bit_9_o   = q.pin_out[PIN_9];
  assign parallel_bit_9_oe  = q.pin_oe[PIN_9];
  assign parallel_bit_10_o  = q.pin_out[PIN_10];
  assign parallel_bit_10_oe = q.pin_oe[PIN_10];
  assign parallel_bit_11_o  = q.pin_out[PIN_11];
  assign parallel_bit_11_oe = q.pin_oe[PIN_11];
  assign parallel_bit_12_o  = q.pin_out[PIN_12];
  assign parallel_bit_12_oe = q.pin_oe[PIN_12];
  assign parallel_bit_13_o  = q.pin_out[PIN_13];
  assign parallel_bit_13_oe = q.pin_oe[PIN_13];

  // ==================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_parallel;
    !serial |=> q.pin_out == $past(q.result[13:9]) && q.pin_oe == {5{$past(en)}};
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel pins wrong");

  property p_chain_in;
    serial && ext |=> !q.pin_oe[PIN_9];
  endproperty
  a_chain_in: assert property (p_chain_in) else $error("chain pin driven");

  property p_chain_done;
    q.state == ST_SHIFT && ext && serial && act_edge && !conv_done &&
      q.bitcnt == 5'(RES_W - 1) |=> q.state == ST_CHAIN && q.bitcnt == 5'(RES_W);
  endproperty
  a_chain_done: assert property (p_chain_done) else $error("chain not after 18");

  property p_int_start;
    q.state == ST_IDLE && !ext ##1 q.state == ST_SHIFT |-> $past(q.busy) == $past(chain_in);
  endproperty
  a_int_start: assert property (p_int_start) else $error("read timing wrong");

  property p_msb_first;
    q.state == ST_IDLE ##1 q.state == ST_SHIFT |-> q.shreg == $past(q.result);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("load not result");

  property p_coding;
    conv_done |=> q.result[RES_W-2:0] == $past(conv_result[RES_W-2:0]) &&
      q.result[RES_W-1] == ($past(conv_result[RES_W-1]) ~^ $past(q.ctrl[CTRL_CODING]));
  endproperty
  a_coding: assert property (p_coding) else $error("coding wrong");

  sequence s_int_shift;
    q.state == ST_SHIFT && !ext && serial && en;
  endsequence
  sequence s_bit_hold;
    $stable(q.shreg) [*7];
  endsequence
  property p_bit_period;
    s_int_shift ##0 q.tcnt == 3'h0 && $past(q.tcnt) == 3'(INT_BIT_CYC - 1)
      ##1 s_int_shift |-> s_bit_hold;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

  property p_marker;
    serial |=> q.pin_out[PIN_12] == ($past(marker_act) ^ $past(q.ctrl[CTRL_MKPOL]));
  endproperty
  a_marker: assert property (p_marker) else $error("marker level wrong");

  property p_clk_dir;
    serial |=> q.pin_oe[PIN_11] == ($past(en) && !$past(ext));
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction");

  sequence s_err_pulse;
    q.rderr [*8] ##1 !q.rderr;
  endsequence
  property p_rderr;
    q.state == ST_SHIFT && ext && serial && conv_done ##1 !$past(q.rderr)
      |-> s_err_pulse;
  endproperty
  a_rderr: assert property (p_rderr) else $error("error pulse wrong");

  property p_busy;
    (conv_start && !conv_done |=> q.busy) and
      (q.busy && !conv_done |=> q.busy) and
      (conv_done |=> !q.busy);
  endproperty
  a_busy: assert property (p_busy) else $error("busy not held");

  property p_enable;
    !en |=> !q.pin_oe[PIN_10];
  endproperty
  a_enable: assert property (p_enable) else $error("output while disabled");

endmodule

/* File: rtl/asrp_pkg.sv */
// constants, field layout and types shared by the serial result port
package asrp_pkg;

  // ==================================================================
  // result word and interface modes
  localparam int unsigned RES_W       = 18;
  localparam logic [1:0]  MODE_SERIAL = 2'h3;

  // ==================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STAT   = 8'h04;
  localparam logic [7:0] OFF_ISTAT  = 8'h08;
  localparam logic [7:0] OFF_IMASK  = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;

  // ==================================================================
  // control field positions and reset values
  localparam int unsigned CTRL_W       = 6;
  localparam int unsigned CTRL_MODE    = 0;
  localparam int unsigned CTRL_CLKSRC  = 2;
  localparam int unsigned CTRL_MKPOL   = 3;
  localparam int unsigned CTRL_EDGEINV = 4;
  localparam int unsigned CTRL_CODING  = 5;
  localparam logic [5:0]  CTRL_RST     = 6'h00;

  // status bit positions
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_FRESH = 1;
  localparam int unsigned STAT_READ  = 2;
  localparam int unsigned STAT_CHAIN = 3;

  // interrupt bit positions and reset values
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_CONV_DONE = 0;
  localparam int unsigned IRQ_READ_DONE = 1;
  localparam int unsigned IRQ_RD_ERR    = 2;
  localparam logic [2:0]  ISTAT_RST     = 3'h0;
  localparam logic [2:0]  IMASK_RST     = 3'h0;

  // shared pin index within the pin vectors
  localparam int unsigned PIN_9  = 0;
  localparam int unsigned PIN_10 = 1;
  localparam int unsigned PIN_11 = 2;
  localparam int unsigned PIN_12 = 3;
  localparam int unsigned PIN_13 = 4;

  // ==================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned INT_SCLK_PERIOD_NS = 80;
  localparam int unsigned INT_BIT_CYC        = INT_SCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned INT_QTR_CYC        = INT_BIT_CYC / 4;
  localparam int unsigned RDERR_PULSE_NS     = 80;
  localparam int unsigned RDERR_CYC          =
    (RDERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==================================================================
  // read sequence states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_CHAIN = 2'b10
  } asrp_state_t;

endpackage

/* File: rtl/asrp_sync.sv */
// two-stage synchroniser for the pin inputs of the serial result port
module asrp_sync
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] din,
  output logic      [3:0] dout
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } asrp_sync_t;

  asrp_sync_t q;
  asrp_sync_t d;

  // ==================================================================
  // stage one feeds stage two only
  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // pins rest high; a low reset value would open the port for two cycles
      q <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

/* File: bench/asrp_host.sv */
// host controller model: selects the port, clocks and collects serial words
module asrp_host
(
  output logic      cs_n,
  output logic      rd_n,
  output logic      sclk_drv,
  output logic      chain_in,
  input  wire logic sclk_pin,
  input  wire logic sdo_pin,
  input  wire logic mark_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // captured words
  logic [35:0] got_a;
  logic [35:0] got_b;
  logic        mark_ok;
  initial
  begin
    {cs_n, rd_n, sclk_drv, chain_in} = 4'hC;
  end
  // ========
  // pin levels, changed just after a pclk edge
  task automatic select(input logic on, input logic ch, input logic ck);
    cs_n <= !on;
    rd_n <= !on;
    chain_in <= ch;
    sclk_drv <= ck;
  endtask
  // ========
  // internal clock: one word under the marker, sampled on both clock edges
  task automatic int_read(input logic act, input logic inv);
    mark_ok = 1'b1;
    // a stale level from the previous setting must not pass for the frame
    wait (mark_pin !== act);
    wait (mark_pin === act);
    for (int k = 17; k >= 0; k--)
    begin
      @(sclk_pin iff sclk_pin === !inv);
      got_a[k] = sdo_pin;
      mark_ok &= (mark_pin === act);
      @(sclk_pin iff sclk_pin === inv);
      got_b[k] = sdo_pin;
    end
  endtask
  // ========
  // external clock: 80 ns period, runs only inside the frame
  // sampling edge first, so the msb is taken before the first shift
  task automatic ext_read(input int n, input logic inv, input logic [17:0] pat);
    #8;
    for (int k = n - 1; k >= 0; k--)
    begin
      sclk_drv = inv;
      got_a[k] = sdo_pin;
      chain_in = (k >= n - 18) ? pat[k-n+18] : !chain_in;
      #40;
      sclk_drv = !inv;
      #40;
    end
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench of the serial result port
module tb
  import asrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // signals
  logic             pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, rdata;
  logic             conv_start, conv_done;
  logic [RES_W-1:0] conv_result, r;
  int               error_cnt, compares, cyc, n;
  wire  [31:0]      prdata;
  wire              pready, pslverr, irq, busy, cs_n, rd_n, sclk_drv, chain_in;
  wire  [4:0]       p_o, p_oe;
  wire              pin9, pin11;
  assign pin9 = p_oe[PIN_9] ? p_o[PIN_9] : chain_in;
  assign pin11 = p_oe[PIN_11] ? p_o[PIN_11] : sclk_drv;

  asrp_port u_asrp_port
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .busy(busy), .cs_n(cs_n), .rd_n(rd_n),
    .parallel_bit_9_i(pin9), .parallel_bit_9_o(p_o[0]), .parallel_bit_9_oe(p_oe[0]),
    .parallel_bit_10_o(p_o[1]), .parallel_bit_10_oe(p_oe[1]),
    .parallel_bit_11_i(pin11), .parallel_bit_11_o(p_o[2]), .parallel_bit_11_oe(p_oe[2]),
    .parallel_bit_12_o(p_o[3]), .parallel_bit_12_oe(p_oe[3]),
    .parallel_bit_13_o(p_o[4]), .parallel_bit_13_oe(p_oe[4])
  );
  asrp_host u_asrp_host
  (
    .cs_n(cs_n), .rd_n(rd_n), .sclk_drv(sclk_drv), .chain_in(chain_in),
    .sclk_pin(pin11), .sdo_pin(p_o[PIN_10]), .mark_pin(p_o[PIN_12])
  );
  // ========
  // clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // ========
  // tasks
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic convert(input logic [17:0] res, input int gap);
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    repeat (gap) @(posedge pclk);
    chk("busy high", busy, 1'b1);
    conv_done <= 1'b1;
    conv_result <= res;
    @(posedge pclk);
    conv_done <= 1'b0;
    @(posedge pclk);
    chk("busy low", busy, 1'b0);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ========
  // tests
  initial
  begin
    {presetn, psel, penable, pwrite, conv_start, conv_done} = '0;
    {paddr, pwdata, conv_result, cyc, error_cnt, compares} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 0);
    chk("ctrl reset", rdata[5:0], CTRL_RST);
    apb(0, OFF_IMASK, 0);
    chk("mask reset", rdata[2:0], IMASK_RST);
    apb(0, 8'h14, 0);
    chk("unmapped", err, 1'b1);
    $display("test registers done");
    // parallel mode: shared pins carry result bits 9..13 while selected
    r = 18'h2A5C3;
    apb(1, OFF_CTRL, 32'h20);
    apb(1, OFF_IMASK, 32'h1);
    u_asrp_host.select(1'b1, 1'b0, 1'b0);
    convert(r, 20);
    repeat (8) @(posedge pclk);
    chk("parallel pins", {p_oe, p_o}, {5'h1F, r[13:9]});
    chk("irq set", irq, 1'b1);
    apb(1, OFF_ISTAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 1'b0);
    apb(1, OFF_IMASK, 32'h0);
    u_asrp_host.select(1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    chk("parallel off", p_oe, 5'h00);
    $display("test parallel done");
    // internal clock, read after conversion, all marker, edge and coding settings
    for (int i = 0; i < 4; i++)
    begin
      r = 18'h12345 ^ (18'h0F0F1 << i);
      apb(1, OFF_CTRL, {26'h0, ~i[0], i[1], i[0], 3'h3});
      u_asrp_host.select(1'b1, 1'b0, 1'b0);
      fork
        u_asrp_host.int_read(~i[0], i[1]);
        convert(r, 20);
      join
      r = i[0] ? r ^ 18'h20000 : r;
      chk("word rising", u_asrp_host.got_a[17:0], r);
      chk("word falling", u_asrp_host.got_b[17:0], r);
      chk("marker held", u_asrp_host.mark_ok, 1'b1);
      repeat (20) @(posedge pclk);
      chk("marker end", {p_oe[3], p_oe[2], p_o[3]}, {2'b11, i[0]});
      u_asrp_host.select(1'b0, 1'b0, 1'b0);
    end
    $display("test internal clock done");
    // read-timing pin high: word leaves during the next conversion
    r = 18'h3C0A5;
    apb(1, OFF_CTRL, 32'h23);
    u_asrp_host.select(1'b1, 1'b1, 1'b0);
    convert(r, 20);
    fork
      u_asrp_host.int_read(1'b1, 1'b0);
      convert(18'h00F0F, 200);
    join
    chk("during conversion", u_asrp_host.got_a[17:0], r);
    u_asrp_host.select(1'b0, 1'b0, 1'b0);
    $display("test read during conversion done");
    // external clock, both edge settings, chained word behind the result
    for (int i = 0; i < 2; i++)
    begin
      r = 18'h2B3D1 ^ {18{i[0]}};
      apb(1, OFF_CTRL, {26'h0, 1'b1, i[0], 4'h7});
      u_asrp_host.select(1'b0, 1'b0, ~i[0]);
      convert(r, 20);
      u_asrp_host.select(1'b1, 1'b0, ~i[0]);
      repeat (8) @(posedge pclk);
      u_asrp_host.ext_read(36, i[0], 18'h2D26B);
      chk("ext word", u_asrp_host.got_a[35:18], r);
      chk("chained", u_asrp_host.got_a[17:0], 18'h2D26B);
      chk("ext enables", {p_oe[0], p_oe[2], p_oe[3], p_oe[4]}, 4'h1);
      u_asrp_host.select(1'b0, 1'b0, ~i[0]);
    end
    $display("test external clock done");
    // conversion finishing in mid-read drops the word and pulses the flag
    apb(1, OFF_CTRL, 32'h27);
    apb(1, OFF_IMASK, 32'h4);
    convert(18'h1A2B3, 20);
    u_asrp_host.select(1'b1, 1'b0, 1'b1);
    repeat (8) @(posedge pclk);
    u_asrp_host.ext_read(5, 1'b0, 18'h0);
    n = 0;
    fork
      convert(18'h05A5A, 20);
      repeat (60) @(posedge pclk) n += int'(p_o[PIN_13] === 1'b1);
    join
    chk("flag width", n, RDERR_CYC);
    chk("irq on error", irq, 1'b1);
    apb(1, OFF_ISTAT, 32'h4);
    apb(0, OFF_ISTAT, 0);
    chk("error cleared", {irq, rdata[IRQ_RD_ERR]}, 2'b00);
    u_asrp_host.select(1'b0, 1'b0, 1'b1);
    $display("test incomplete read done");
    stop_test();
  end
endmodule
